// file: hdl/fsq_ctrl.sv
// Flash page erase, page write and word read sequencer
//
// Local design decisions: the register offsets and the address-and-strobe port.
`include "fsq_map.svh"
`default_nettype none
module fsq_ctrl #(
    parameter int ERASE_CYC = `ERASE_CYC,
    parameter int PROG_CYC = `PROG_CYC,
    parameter int UNLOCK_CYC = `UNLOCK_CYC,
    parameter int CW = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire fsq_pkg::reg_req_s req_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output fsq_pkg::flash_cmd_s fcmd_o,
    input wire logic [15:0] flash_rdata_i
);
    localparam logic [23:0] KEY = `UNLOCK_KEY;

    function automatic logic hit(input fsq_pkg::reg_req_s q, input logic [7:0] ofs);
        hit = q.addr == ofs;
    endfunction : hit

    // R9 - page number and word
    function automatic logic [13:0] faddr(input logic [5:0] hi, input logic [7:0] lo,
                                          input logic [4:0] w);
        faddr = {hi, lo[7:5], w};
    endfunction : faddr

    fsq_pkg::fsq_state_e state_r;
    fsq_pkg::flash_cmd_s fcmd_r;
    logic flag_r, trig_r, wbusy_r, rden_r, rbusy_r, erase_sel_r, clwb_r, irq_r;
    logic [2:0] mode_r, stat_r, mask_r, stat_nxt;
    logic [7:0] addr_lo_r, rd_lo_r, rd_hi_r, wd_lo_r, rdata_r, rd_mux;
    logic [5:0] addr_hi_r;
    logic [1:0] key_stage_r;
    logic [CW-1:0] unl_cnt_r, cnt_r;
    logic [4:0] word_r, rb_addr;
    logic [15:0] rb_data;
    logic [2:0] wmode;
    logic wr_ctrl, wr_key, key_match, key_ok, buf_wr, wb_clr, idle;
    logic er_done, wr_done, rd_done;
    logic [6:0] prog_cnt_r;

    ////////////////////////////////////////////////////////////////
    // Decode
    assign wmode = req_i.wdata[`B_MODE +: 3];
    assign wr_ctrl = req_i.wr && hit(req_i, `OFS_CTRL);
    assign wr_key = req_i.wr && hit(req_i, `OFS_KEY);
    assign key_match = wr_key && KEY[8*key_stage_r +: 8] == req_i.wdata;
    assign key_ok = trig_r && key_match && key_stage_r == 2'h2;
    assign idle = state_r == fsq_pkg::ST_IDLE && !wbusy_r && !rbusy_r;
    // R5 - buffer gated by flag
    assign buf_wr = req_i.wr && hit(req_i, `OFS_DHI) && flag_r && idle;
    assign er_done = state_r == fsq_pkg::ST_ERASE && cnt_r == '0;
    assign wr_done = state_r == fsq_pkg::ST_PROG && cnt_r == '0 && word_r == `LAST_WORD;
    assign rd_done = state_r == fsq_pkg::ST_READ_CAP;
    // R13 - clear after page write
    assign wb_clr = clwb_r || wr_done;
    assign rb_addr = state_r == fsq_pkg::ST_PROG ? word_r + 5'h01 : 5'h00;

    fsq_wbuf #(.WORDS(`PAGE_WORDS), .DW(16), .AW(5)) u_wbuf (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(buf_wr),
        .waddr_i(addr_lo_r[4:0]),
        .wdata_i({req_i.wdata, wd_lo_r}),
        .clr_i(wb_clr),
        .raddr_i(rb_addr),
        .rdata_o(rb_data)
    );

    ////////////////////////////////////////////////////////////////
    // Unlock procedure
    // R4 - flag set by hardware only
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_r <= 1'b0;
        end else if (key_ok) begin
            flag_r <= 1'b1;
        end else if (wr_ctrl && !req_i.wdata[`B_FLAG]) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trig_r <= 1'b0;
            unl_cnt_r <= '0;
        end else if (key_ok || (trig_r && unl_cnt_r == '0)) begin
            trig_r <= 1'b0;
        end else if (wr_ctrl && req_i.wdata[`B_TRIG] && wmode == `MODE_UNLOCK) begin
            trig_r <= 1'b1;
            unl_cnt_r <= CW'(UNLOCK_CYC - 1);
        end else if (trig_r) begin
            unl_cnt_r <= unl_cnt_r - 1'b1;
        end
    end

    // Any wrong byte restarts the pattern
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            key_stage_r <= 2'h0;
        end else if (!trig_r || (wr_key && (!key_match || key_ok))) begin
            key_stage_r <= 2'h0;
        end else if (wr_key) begin
            key_stage_r <= key_stage_r + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control bits
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_r <= 3'h0;
            rden_r <= 1'b0;
        end else if (wr_ctrl) begin
            mode_r <= wmode;
            rden_r <= req_i.wdata[`B_RDEN];
        end
    end

    // R6 - busy until done
    // R14 - start ignored when locked
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wbusy_r <= 1'b0;
            erase_sel_r <= 1'b0;
        end else if (er_done || wr_done) begin
            wbusy_r <= 1'b0;
        end else if (wr_ctrl && req_i.wdata[`B_WT] && flag_r && idle
                     && (wmode == `MODE_WRITE || wmode == `MODE_ERASE)) begin
            wbusy_r <= 1'b1;
            erase_sel_r <= wmode == `MODE_ERASE;
        end
    end

    // R7 - read needs enable
    // R8 - cleared at read end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rbusy_r <= 1'b0;
        end else if (rd_done) begin
            rbusy_r <= 1'b0;
        end else if (wr_ctrl && req_i.wdata[`B_RD] && rden_r && idle
                     && wmode == `MODE_READ) begin
            rbusy_r <= 1'b1;
        end
    end

    // One-cycle manual buffer clear
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clwb_r <= 1'b0;
        end else begin
            clwb_r <= req_i.wr && hit(req_i, `OFS_CTRL2) && req_i.wdata[`B_CLWB];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Address and data
    // R11 - load buffer, bump address
    // R12 - hold at last word
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_lo_r <= 8'h00;
        end else if (req_i.wr && hit(req_i, `OFS_ALO)) begin
            addr_lo_r <= req_i.wdata;
        end else if (buf_wr && addr_lo_r[4:0] != `LAST_WORD) begin
            addr_lo_r <= addr_lo_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_hi_r <= 6'h00;
            wd_lo_r <= 8'h00;
        end else if (req_i.wr) begin
            if (hit(req_i, `OFS_AHI)) begin
                addr_hi_r <= req_i.wdata[5:0];
            end
            if (hit(req_i, `OFS_DLO)) begin
                wd_lo_r <= req_i.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_lo_r <= 8'h00;
            rd_hi_r <= 8'h00;
        end else if (rd_done) begin
            rd_lo_r <= flash_rdata_i[7:0];
            rd_hi_r <= flash_rdata_i[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer
    // R1 - whole page or one word
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= fsq_pkg::ST_IDLE;
            fcmd_r <= '0;
            cnt_r <= '0;
            word_r <= 5'h00;
        end else begin
            unique case (state_r)
                fsq_pkg::ST_IDLE: begin
                    fcmd_r <= '0;
                    word_r <= 5'h00;
                    if (wbusy_r && erase_sel_r) begin
                        state_r <= fsq_pkg::ST_ERASE;
                        cnt_r <= CW'(ERASE_CYC - 1);
                        fcmd_r.erase <= 1'b1;
                        fcmd_r.addr <= faddr(addr_hi_r, addr_lo_r, 5'h00);
                    end else if (wbusy_r) begin
                        state_r <= fsq_pkg::ST_PROG;
                        cnt_r <= CW'(PROG_CYC - 1);
                        fcmd_r.prog <= 1'b1;
                        fcmd_r.addr <= faddr(addr_hi_r, addr_lo_r, 5'h00);
                        fcmd_r.wdata <= rb_data;
                    end else if (rbusy_r) begin
                        state_r <= fsq_pkg::ST_READ;
                        fcmd_r.rd <= 1'b1;
                        fcmd_r.addr <= faddr(addr_hi_r, addr_lo_r, addr_lo_r[4:0]);
                    end
                end
                fsq_pkg::ST_ERASE: begin
                    cnt_r <= cnt_r - 1'b1;
                    if (er_done) begin
                        fcmd_r.erase <= 1'b0;
                        state_r <= fsq_pkg::ST_IDLE;
                    end
                end
                fsq_pkg::ST_PROG: begin
                    cnt_r <= cnt_r - 1'b1;
                    fcmd_r.prog <= 1'b0;
                    if (wr_done) begin
                        state_r <= fsq_pkg::ST_IDLE;
                    end else if (cnt_r == '0) begin
                        word_r <= word_r + 5'h01;
                        cnt_r <= CW'(PROG_CYC - 1);
                        fcmd_r.prog <= 1'b1;
                        fcmd_r.addr <= faddr(addr_hi_r, addr_lo_r, word_r + 5'h01);
                        fcmd_r.wdata <= rb_data;
                    end
                end
                // Macro returns data the cycle after its strobe
                fsq_pkg::ST_READ: begin
                    fcmd_r.rd <= 1'b0;
                    state_r <= fsq_pkg::ST_READ_CAP;
                end
                fsq_pkg::ST_READ_CAP: begin
                    state_r <= fsq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Interrupts and read port
    // Set beats the read-clear
    always_comb begin
        stat_nxt = stat_r & ~(req_i.rd && hit(req_i, `OFS_STAT) ? 3'h7 : 3'h0);
        stat_nxt[`EV_ERASE] = stat_nxt[`EV_ERASE] | er_done;
        stat_nxt[`EV_WRITE] = stat_nxt[`EV_WRITE] | wr_done;
        stat_nxt[`EV_READ] = stat_nxt[`EV_READ] | rd_done;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stat_r <= 3'h0;
            mask_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r <= |(stat_nxt & mask_r);
            if (req_i.wr && hit(req_i, `OFS_MASK)) begin
                mask_r <= req_i.wdata[2:0];
            end
        end
    end

    always_comb begin
        unique case (req_i.addr)
            `OFS_CTRL: rd_mux = {flag_r, mode_r, trig_r, wbusy_r, rden_r, rbusy_r};
            `OFS_ALO: rd_mux = addr_lo_r;
            `OFS_AHI: rd_mux = {2'b00, addr_hi_r};
            `OFS_DLO: rd_mux = wd_lo_r;
            `OFS_RLO: rd_mux = rd_lo_r;
            `OFS_RHI: rd_mux = rd_hi_r;
            `OFS_STAT: rd_mux = {5'h00, stat_r};
            `OFS_MASK: rd_mux = {5'h00, mask_r};
            `OFS_CTRL2: rd_mux = {7'h00, clwb_r};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= req_i.rd ? rd_mux : 8'h00;
        end
    end

    assign rdata_o = rdata_r;
    assign irq_o = irq_r;
    assign fcmd_o = fcmd_r;

    ////////////////////////////////////////////////////////////////
    // Checks
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prog_cnt_r <= 7'h00;
        end else if (state_r == fsq_pkg::ST_IDLE) begin
            prog_cnt_r <= 7'h00;
        end else if (fcmd_r.prog) begin
            prog_cnt_r <= prog_cnt_r + 7'h01;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_rd_run;
        ##1 fcmd_r.rd ##1 (!fcmd_r.rd && rbusy_r) ##1 !rbusy_r;
    endsequence

    property p_r1; wr_done |-> prog_cnt_r + 7'(fcmd_r.prog) == 7'h20; endproperty
    a_r1: assert property (p_r1) else $error("page write not 32 words"); // R1
    property p_r2; fcmd_r.prog |-> fcmd_r.addr[4:0] == word_r; endproperty
    a_r2: assert property (p_r2) else $error("program word mismatch"); // R2
    property p_r4; $rose(flag_r) |-> $past(trig_r && key_stage_r == 2'h2 && wr_key);
    endproperty
    a_r4: assert property (p_r4) else $error("flag set without unlock"); // R4
    // Refused load must not move the word address
    property p_r5; req_i.wr && hit(req_i, `OFS_DHI) && !flag_r |=>
        addr_lo_r == $past(addr_lo_r);
    endproperty
    a_r5: assert property (p_r5) else $error("buffer load while locked"); // R5
    property p_r6; $fell(wbusy_r) |-> $past(er_done || wr_done); endproperty
    a_r6: assert property (p_r6) else $error("write busy fell early"); // R6
    property p_r8; $rose(rbusy_r) |-> s_rd_run; endproperty
    a_r8: assert property (p_r8) else $error("read sequence wrong"); // R8
    property p_r9; $rose(fcmd_r.erase) |->
        fcmd_r.addr == {$past(addr_hi_r), $past(addr_lo_r[7:5]), 5'h00};
    endproperty
    a_r9: assert property (p_r9) else $error("erase page address wrong"); // R9
    property p_r10; $rose(wbusy_r) |-> erase_sel_r == (mode_r == `MODE_ERASE)
        && (mode_r == `MODE_ERASE || mode_r == `MODE_WRITE);
    endproperty
    a_r10: assert property (p_r10) else $error("mode decode wrong"); // R10
    property p_r11; buf_wr && addr_lo_r[4:0] != `LAST_WORD |=>
        addr_lo_r == $past(addr_lo_r) + 8'h01;
    endproperty
    a_r11: assert property (p_r11) else $error("address not bumped"); // R11
    property p_r12; buf_wr && addr_lo_r[4:0] == `LAST_WORD |=>
        addr_lo_r == $past(addr_lo_r);
    endproperty
    a_r12: assert property (p_r12) else $error("address passed page end"); // R12
    property p_r13; wr_done |=> rb_data == `WBUF_CLR_VAL; endproperty
    a_r13: assert property (p_r13) else $error("buffer not cleared"); // R13
    property p_r14; wr_ctrl && !flag_r && !wbusy_r |=> !wbusy_r [*2]; endproperty
    a_r14: assert property (p_r14) else $error("start taken while locked"); // R14
endmodule : fsq_ctrl
`default_nettype wire

// file: inc/fsq_map.svh
// Register map, field positions and timing of the flash sequencer
// Contract
// R1 - Erase and write whole pages, read single words
// R2 - Page and write buffer hold 32 words
// R3 - Software erases a page before writing it
// R4 - Enabled flag rises only after successful unlock
// R5 - Buffer accepts data only while enabled
// R6 - Write start bit stays high until done
// R7 - Reads need the read enable bit set
// R8 - Read start bit clears when data ready
// R9 - Page from high byte and low[7:5]
// R10 - Mode codes: write, erase, read, unlock
// R11 - High data write loads buffer, bumps address
// R12 - Word address holds at last word
// R13 - Buffer clears after page write completes
// R14 - Start ignored while erase/write not enabled
`ifndef FSQ_MAP_SVH
`define FSQ_MAP_SVH

`define OFS_CTRL 8'h00
`define OFS_ALO 8'h01
`define OFS_AHI 8'h02
`define OFS_DLO 8'h03
`define OFS_DHI 8'h04
`define OFS_RLO 8'h05
`define OFS_RHI 8'h06
`define OFS_STAT 8'h07
`define OFS_MASK 8'h08
`define OFS_CTRL2 8'h09
`define OFS_KEY 8'h0A

`define B_FLAG 7
`define B_MODE 4
`define B_TRIG 3
`define B_WT 2
`define B_RDEN 1
`define B_RD 0
`define B_CLWB 0

`define MODE_WRITE 3'h0
`define MODE_ERASE 3'h1
`define MODE_READ 3'h3
`define MODE_UNLOCK 3'h6

`define EV_ERASE 0
`define EV_WRITE 1
`define EV_READ 2

// Arbitrary unlock pattern, low byte first
`define UNLOCK_KEY 24'hC3A55A
`define WBUF_CLR_VAL 16'hFFFF
`define PAGE_WORDS 32
`define LAST_WORD 5'h1F

`define CLK_MHZ 20
`define ERASE_TIME_US 2000
`define PROG_TIME_US 20
`define UNLOCK_TIME_US 1000
`define ERASE_CYC (`ERASE_TIME_US * `CLK_MHZ)
`define PROG_CYC (`PROG_TIME_US * `CLK_MHZ)
`define UNLOCK_CYC (`UNLOCK_TIME_US * `CLK_MHZ)

`endif

// file: inc/fsq_pkg.sv
// Types shared by the flash sequencer files
`default_nettype none
package fsq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ERASE, ST_PROG, ST_READ, ST_READ_CAP
    } fsq_state_e;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
    typedef struct packed {
        logic erase;
        logic prog;
        logic rd;
        logic [13:0] addr;
        logic [15:0] wdata;
    } flash_cmd_s;
endpackage : fsq_pkg
`default_nettype wire

// file: hdl/fsq_wbuf.sv
// Page write buffer in flip-flops
`include "fsq_map.svh"
`default_nettype none
module fsq_wbuf #(
    parameter int WORDS = `PAGE_WORDS,
    parameter int DW = 16,
    parameter int AW = 5
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic clr_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_r [WORDS];

    // R2 - one entry per page word
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                mem_r[i] <= DW'(`WBUF_CLR_VAL);
            end else if (clr_i) begin
                mem_r[i] <= DW'(`WBUF_CLR_VAL);
            end else if (wr_i && waddr_i == AW'(i)) begin
                mem_r[i] <= wdata_i;
            end
        end
    end

    assign rdata_o = mem_r[raddr_i];
endmodule : fsq_wbuf
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the flash page sequencer
`include "fsq_map.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int ERASE_N = 20;
    localparam int PROG_N = 3;
    localparam int UNLOCK_N = 50;
    localparam logic [23:0] UKEY = `UNLOCK_KEY;

    logic sys_clk_i;
    logic rst_b_i;
    fsq_pkg::reg_req_s req;
    logic [7:0] rdata;
    logic irq;
    fsq_pkg::flash_cmd_s fcmd;
    logic [15:0] flash_rdata;
    int errors;
    int checked;
    int np;
    int ecnt;
    logic [13:0] eaddr;
    logic [13:0] raddr;
    logic [13:0] pa [0:31];
    logic [15:0] pd [0:31];
    logic [7:0] v;

    fsq_ctrl #(
        .ERASE_CYC(ERASE_N),
        .PROG_CYC(PROG_N),
        .UNLOCK_CYC(UNLOCK_N),
        .CW(16)
    ) u_dut (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .req_i(req),
        .rdata_o(rdata),
        .irq_o(irq),
        .fcmd_o(fcmd),
        .flash_rdata_i(flash_rdata)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flash macro stand-in; read data is invalid outside its one cycle
    always @(posedge sys_clk_i) begin
        if (fcmd.prog === 1'b1) begin
            if (np < 32) begin
                pa[np] <= fcmd.addr;
                pd[np] <= fcmd.wdata;
            end
            np <= np + 1;
        end
        if (fcmd.erase === 1'b1) begin
            ecnt <= ecnt + 1;
            eaddr <= fcmd.addr;
        end
        if (fcmd.rd === 1'b1) begin
            raddr <= fcmd.addr;
        end
        flash_rdata <= (fcmd.rd === 1'b1) ? {2'b10, fcmd.addr} : ~{2'b10, raddr};
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk_i);
        req <= '0;
    endtask : wr_reg

    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk_i);
        req <= '0;
        @(negedge sys_clk_i);
        d = rdata;
    endtask : rd_reg

    task automatic wait_idle(input int b);
        logic [7:0] c;
        int n;
        n = 0;
        rd_reg(`OFS_CTRL, c);
        while (c[b] !== 1'b0 && n < 200) begin
            rd_reg(`OFS_CTRL, c);
            n++;
        end
        chk("busy bit", 16'h0000, 16'(c[b]));
    endtask : wait_idle

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        errors++;
        test_done();
    end

    initial begin
        errors = 0;
        checked = 0;
        np = 0;
        ecnt = 0;
        req = '0;
        flash_rdata = 16'h0000;
        rst_b_i = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(negedge sys_clk_i);
        chk("reset outputs", 16'h0000, {5'h00, rdata, irq, fcmd.erase, fcmd.prog});
        rd_reg(`OFS_CTRL, v);
        chk("ctrl reset", 16'h0000, 16'(v));
        rd_reg(8'h3F, v);
        chk("unmapped", 16'h0000, 16'(v));
        // Locked: buffer loads and starts are refused
        wr_reg(`OFS_AHI, 8'h01);
        wr_reg(`OFS_ALO, 8'h40);
        wr_reg(`OFS_DLO, 8'h11);
        wr_reg(`OFS_DHI, 8'h22);
        rd_reg(`OFS_ALO, v);
        chk("alo locked", 16'h0040, 16'(v));
        wr_reg(`OFS_CTRL, 8'h04);
        rd_reg(`OFS_CTRL, v);
        chk("write start locked", 16'h0000, 16'(v[`B_WT]));
        wr_reg(`OFS_CTRL, 8'h14);
        repeat (4) @(posedge sys_clk_i);
        chk("prog erase locked", 16'h0000, 16'(np + ecnt));
        // Single word read
        wr_reg(`OFS_AHI, 8'h3F);
        wr_reg(`OFS_ALO, 8'hE7);
        wr_reg(`OFS_CTRL, 8'h31);
        rd_reg(`OFS_CTRL, v);
        chk("read no enable", 16'h0000, 16'(v[`B_RD]));
        wr_reg(`OFS_CTRL, 8'h32);
        wr_reg(`OFS_CTRL, 8'h33);
        wait_idle(`B_RD);
        chk("read addr", 16'h3FE7, 16'(raddr));
        rd_reg(`OFS_RLO, v);
        chk("read lo", 16'h00E7, 16'(v));
        rd_reg(`OFS_RHI, v);
        chk("read hi", 16'h00BF, 16'(v));
        chk("irq masked", 16'h0000, 16'(irq));
        rd_reg(`OFS_STAT, v);
        chk("stat read", 16'h0004, 16'(v));
        // Unlock, first with a wrong byte
        wr_reg(`OFS_CTRL, 8'hE8);
        wr_reg(`OFS_KEY, UKEY[7:0]);
        wr_reg(`OFS_KEY, UKEY[15:8]);
        wr_reg(`OFS_KEY, ~UKEY[23:16]);
        rd_reg(`OFS_CTRL, v);
        chk("flag wrong key", 16'h0000, 16'(v[`B_FLAG]));
        wr_reg(`OFS_CTRL, 8'hE8);
        wr_reg(`OFS_KEY, UKEY[7:0]);
        wr_reg(`OFS_KEY, UKEY[15:8]);
        wr_reg(`OFS_KEY, UKEY[23:16]);
        rd_reg(`OFS_CTRL, v);
        chk("flag unlocked", 16'h0001, 16'(v[`B_FLAG]));
        // Reserved and unlock modes never start a write
        foreach (pa[i]) begin
            if (i inside {2, 4, 5, 6, 7}) begin
                wr_reg(`OFS_CTRL, {1'b1, 3'(i), 4'h4});
                rd_reg(`OFS_CTRL, v);
                chk("mode refused", 16'h0000, 16'(v[`B_WT]));
            end
        end
        // Page erase of page 10
        wr_reg(`OFS_AHI, 8'h01);
        wr_reg(`OFS_ALO, 8'h40);
        wr_reg(`OFS_CTRL, 8'h94);
        wait_idle(`B_WT);
        chk("erase length", 16'(ERASE_N), 16'(ecnt));
        chk("erase addr", 16'h0140, 16'(eaddr));
        rd_reg(`OFS_STAT, v);
        chk("stat erase", 16'h0001, 16'(v));
        // Fill the whole buffer, address bumps then holds
        for (int i = 0; i < 32; i++) begin
            wr_reg(`OFS_DLO, 8'h0F + 8'(i));
            wr_reg(`OFS_DHI, 8'hC0 + 8'(i));
            if (i == 0) begin
                rd_reg(`OFS_ALO, v);
                chk("alo bump", 16'h0041, 16'(v));
            end
        end
        rd_reg(`OFS_ALO, v);
        chk("alo hold", 16'h005F, 16'(v));
        wr_reg(`OFS_MASK, 8'h02);
        np = 0;
        wr_reg(`OFS_CTRL, 8'h84);
        rd_reg(`OFS_CTRL, v);
        chk("write busy", 16'h0001, 16'(v[`B_WT]));
        wait_idle(`B_WT);
        chk("word count", 16'h0020, 16'(np));
        for (int i = 0; i < 32; i++) begin
            chk("prog addr", 16'h0140 + 16'(i), 16'(pa[i]));
            chk("prog data", {8'hC0 + 8'(i), 8'h0F + 8'(i)}, pd[i]);
        end
        @(negedge sys_clk_i);
        chk("irq raised", 16'h0001, 16'(irq));
        rd_reg(`OFS_STAT, v);
        chk("stat write", 16'h0002, 16'(v));
        repeat (2) @(negedge sys_clk_i);
        chk("irq cleared", 16'h0000, 16'(irq));
        // Buffer is blank after a completed write
        np = 0;
        wr_reg(`OFS_CTRL, 8'h84);
        wait_idle(`B_WT);
        chk("word count 2", 16'h0020, 16'(np));
        for (int i = 0; i < 32; i++) begin
            chk("cleared data", `WBUF_CLR_VAL, pd[i]);
        end
        // Manual clear drops a word loaded at the held last address
        wr_reg(`OFS_DLO, 8'h5A);
        wr_reg(`OFS_DHI, 8'hA5);
        wr_reg(`OFS_CTRL2, 8'h01);
        rd_reg(`OFS_CTRL2, v);
        chk("clear self", 16'h0000, 16'(v));
        np = 0;
        wr_reg(`OFS_CTRL, 8'h84);
        wait_idle(`B_WT);
        chk("word count 3", 16'h0020, 16'(np));
        chk("manual clear", `WBUF_CLR_VAL, pd[31]);
        test_done();
    end
endmodule : testbench
`default_nettype wire
